// file: pcl_checker.sv
// port assertions for the bus, loop switching, rail mode and interrupt outputs
// assumes a bind onto pcl_regs with a single clock domain
`timescale 1ns/1ps
module pcl_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic inband_up_i,
    input wire logic inband_valid_i,
    input wire logic inband_strobe_i,
    input wire logic rx_dual_rail_sel_o,
    input wire logic tx_dual_rail_sel_o,
    input wire logic remote_loop_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////
    // strobes in the current valid run, saturating so long runs stay safe
    logic [5:0] run_q;
    logic [5:0] run_d;
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && wb_we_i;
    assign run_d = !inband_valid_i ? 6'h00 :
        (inband_strobe_i && run_q != 6'h3f) ? run_q + 6'h01 : run_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_q <= 6'h00;
        end else begin
            run_q <= run_d;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_ack; req && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("ack not one cycle after request");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ack longer than one cycle");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle)
        else $error("read data without ack");
    property p_upper; wb_dat_o[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    property p_cause; wb_ack_o |-> $past(req); endproperty
    a_cause: assert property (p_cause)
        else $error("ack without request");
    property p_rise;
        $rose(remote_loop_o) |-> $past(inband_up_i) && run_q >= 6'h10;
    endproperty
    a_rise: assert property (p_rise)
        else $error("remote loop closed too early");
    property p_fall;
        $fell(remote_loop_o) |-> !$past(inband_up_i) || $past(wr) ||
            $past(wr, 2);
    endproperty
    a_fall: assert property (p_fall)
        else $error("remote loop opened without cause");
    property p_rail;
        $changed({rx_dual_rail_sel_o, tx_dual_rail_sel_o}) |->
            $past(wr) || $past(wr, 2);
    endproperty
    a_rail: assert property (p_rail)
        else $error("rail mode moved without a write");
    property p_irq; $fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt dropped without a write");
    c_rise: cover property ($rose(remote_loop_o));
    c_irq: cover property ($fell(irq_o));
    c_wr: cover property (wr && wb_ack_o);
endmodule // pcl_checker

bind pcl_regs pcl_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .inband_up_i(inband_up_i),
    .inband_valid_i(inband_valid_i), .inband_strobe_i(inband_strobe_i),
    .rx_dual_rail_sel_o(rx_dual_rail_sel_o),
    .tx_dual_rail_sel_o(tx_dual_rail_sel_o),
    .remote_loop_o(remote_loop_o), .irq_o(irq_o));

// file: pcl_clk_sel.sv
// registered eight to one selector for one recovered clock output
// assumes channel clocks are synchronous samples on clk_i
`timescale 1ns/1ps
module pcl_clk_sel (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [pcl_pkg::CH_N-1:0] ch_clk_i,
    input wire logic [pcl_pkg::SEL_W-1:0] sel_i,
    output logic clk_o
);
    import pcl_pkg::*;

    // code n picks channel n+1, which is bit n of the vector
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_o <= 1'b0;
        end else begin
            clk_o <= ch_clk_i[sel_i];
        end
    end
endmodule // pcl_clk_sel

// file: pcl_framer_model.sv
// framer side model: channel clocks and in-band loop pattern stream
// assumes go_i and up_i change just after a rising edge
`timescale 1ns/1ps
module pcl_framer_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire logic up_i,
    output logic [7:0] ch_clk_o,
    output logic valid_o,
    output logic up_o,
    output logic strobe_o
);
    // johnson ring gives every channel its own phase each cycle;
    // idle code line wobbles so a stale value is never trusted
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch_clk_o <= 8'h00;
            valid_o <= 1'b0;
            up_o <= 1'b0;
            strobe_o <= 1'b0;
        end else begin
            ch_clk_o <= {ch_clk_o[6:0], ~ch_clk_o[7]};
            valid_o <= go_i;
            up_o <= go_i ? up_i : ~up_o;
            strobe_o <= go_i && valid_o && !strobe_o; // every other cycle
        end
    end
endmodule // pcl_framer_model

// file: pcl_pkg.sv
// constants, register map and field layout of the port clock / loop block
// assumes a 100 MHz clock and a 32-bit classic wishbone register port
// Contract
// (RULE1) output 7 clock comes from channel code+1, field bits 6:4 of route_6_7
// (RULE2) output 6 clock comes from channel code+1, field bits 2:0 of route_6_7
// (RULE3) output 8 clock comes from channel code+1, field bits 2:0 of route_8
// (RULE4) time codes 00/01 need 16 or 32 consecutive valid loop patterns
// (RULE5) time codes 10/11 need the pattern valid for four or five seconds
// (RULE6) auto switch bit 0 enables remote loop set/release by line codes
// (RULE7) an active local loop suppresses automatic remote loop switching
// (RULE8) software never enables system and line auto switching together
// (RULE9) loop up or down detection may raise an interrupt when unmasked
// (RULE10) mask bits 4 and 3 gate the two transmit clock source events
// (RULE11) rail mode bit 1 picks single or dual rail receive toward framer
// (RULE12) rail mode bit 0 picks single or dual rail transmit from framer
// (RULE13) reserved bits read as zero and writes to them do nothing
package pcl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ROUTE_6_7 = 8'hd5;
    localparam logic [7:0] IDX_ROUTE_8 = 8'hd6;
    localparam logic [7:0] IDX_DETECT_TIME = 8'hd7;
    localparam logic [7:0] IDX_AUTO_LOOP = 8'hd9;
    localparam logic [7:0] IDX_TX_CLK_MASK = 8'hdf;
    localparam logic [7:0] IDX_RAIL_MODE = 8'he1;
    localparam logic [7:0] IDX_LINE_MODE_0 = 8'he2;
    localparam logic [7:0] IDX_MASK_SIX = 8'he3;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'he4;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'he5;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'he6;

    // reset values
    localparam logic [7:0] RST_ROUTE_6_7 = 8'h65;
    localparam logic [7:0] RST_ROUTE_8 = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // writable bit masks, everything else is reserved
    localparam logic [7:0] WM_ROUTE_6_7 = 8'h77;
    localparam logic [7:0] WM_ROUTE_8 = 8'h07;
    localparam logic [7:0] WM_DETECT_TIME = 8'h30;
    localparam logic [7:0] WM_AUTO_LOOP = 8'h01;
    localparam logic [7:0] WM_TX_CLK_MASK = 8'h18;
    localparam logic [7:0] WM_RAIL_MODE = 8'h03;
    localparam logic [7:0] WM_LINE_MODE_0 = 8'h02;
    localparam logic [7:0] WM_IRQ = 8'h1b;

    // field positions
    localparam int SEL_W = 3;
    localparam int CH_N = 8;
    localparam int R6_LSB = 0;
    localparam int R7_LSB = 4;
    localparam int R8_LSB = 0;
    localparam int DT_LSB = 4;
    localparam int AUTO_BIT = 0;
    localparam int LOCAL_LOOP_BIT = 1;
    localparam int TX_RAIL_BIT = 0;
    localparam int RX_RAIL_BIT = 1;
    // interrupt layout: status, clear, enable and masks share it
    localparam int EV_UP = 0;
    localparam int EV_DOWN = 1;
    localparam int EV_TXA = 3;
    localparam int EV_TXB = 4;

    // detection time codes
    typedef enum logic [1:0] {
        PCL_DT_16 = 2'b00,
        PCL_DT_32 = 2'b01,
        PCL_DT_4S = 2'b10,
        PCL_DT_5S = 2'b11
    } pcl_dt_t;

    // qualification figures
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] PAT_COUNT_A = 13'h0010;
    localparam logic [CNT_W-1:0] PAT_COUNT_B = 13'h0020;
    localparam int TIME_A_S = 4;
    localparam int TIME_B_S = 5;
    localparam int MS_PER_S = 1000;
    localparam logic [CNT_W-1:0] MS_COUNT_A = CNT_W'(TIME_A_S * MS_PER_S);
    localparam logic [CNT_W-1:0] MS_COUNT_B = CNT_W'(TIME_B_S * MS_PER_S);
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int TICK_W = 17;
endpackage

// file: pcl_regs.sv
// port clock routing, in-band loop qualification and rail mode registers
// assumes a classic wishbone master and framer inputs synchronous to clk_i
`timescale 1ns/1ps
module pcl_regs #(
    parameter int MS_CYCLES = pcl_pkg::MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [pcl_pkg::CH_N-1:0] ch_clk_i,
    input wire logic inband_valid_i,
    input wire logic inband_up_i,
    input wire logic inband_strobe_i,
    input wire logic tx_clock_source_event_a_i,
    input wire logic tx_clock_source_event_b_i,
    output logic recovered_clock_out_6_o,
    output logic recovered_clock_out_7_o,
    output logic recovered_clock_out_8_o,
    output logic rx_dual_rail_sel_o,
    output logic tx_dual_rail_sel_o,
    output logic remote_loop_o,
    output logic irq_o
);
    import pcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register bus decode

    logic [7:0] route_6_7_q;
    logic [7:0] route_8_q;
    logic [7:0] detect_time_q;
    logic [7:0] auto_loop_q;
    logic [7:0] tx_clk_mask_q;
    logic [7:0] rail_mode_q;
    logic [7:0] line_mode_0_q;
    logic [7:0] mask_six_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_status_d;
    logic [7:0] irq_enable_q;
    logic [7:0] irq_clear;
    logic [7:0] ev_set;
    logic [7:0] rd_byte;
    logic [7:0] idx;
    logic access;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] wm_mask_six;

    // mask six only covers the loop up and down events; the transmit
    // clock events have their own mask, so a stray bit here must not block
    assign wm_mask_six = WM_IRQ & ~WM_TX_CLK_MASK;

    // ack drops for a cycle after each answer; a held request is answered again every other cycle
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[9:2];
    assign wr = access & wb_we_i & wb_sel_i[0] & (wb_adr_i[31:10] == 22'h0);
    assign wdat = wb_dat_i[7:0];

    // reserved bits come back as zero [RULE13]
    assign rd_byte =
        (wb_adr_i[31:10] != 22'h0) ? RST_ZERO :
        (idx == IDX_ROUTE_6_7) ? route_6_7_q :
        (idx == IDX_ROUTE_8) ? route_8_q :
        (idx == IDX_DETECT_TIME) ? detect_time_q :
        (idx == IDX_AUTO_LOOP) ? auto_loop_q :
        (idx == IDX_TX_CLK_MASK) ? tx_clk_mask_q :
        (idx == IDX_RAIL_MODE) ? rail_mode_q :
        (idx == IDX_LINE_MODE_0) ? line_mode_0_q :
        (idx == IDX_MASK_SIX) ? mask_six_q :
        (idx == IDX_IRQ_STATUS) ? irq_status_q :
        (idx == IDX_IRQ_ENABLE) ? irq_enable_q : RST_ZERO;

    // ack one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; only writable bits are stored [RULE13]

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            route_6_7_q <= RST_ROUTE_6_7;
            route_8_q <= RST_ROUTE_8;
            detect_time_q <= RST_ZERO;
            auto_loop_q <= RST_ZERO;
            tx_clk_mask_q <= RST_ZERO;
            rail_mode_q <= RST_ZERO;
            line_mode_0_q <= RST_ZERO;
            mask_six_q <= RST_ZERO;
            irq_enable_q <= RST_ZERO;
        end else if (wr) begin
            if (idx == IDX_ROUTE_6_7) route_6_7_q <= wdat & WM_ROUTE_6_7;
            if (idx == IDX_ROUTE_8) route_8_q <= wdat & WM_ROUTE_8;
            if (idx == IDX_DETECT_TIME) detect_time_q <= wdat & WM_DETECT_TIME;
            if (idx == IDX_AUTO_LOOP) auto_loop_q <= wdat & WM_AUTO_LOOP;
            if (idx == IDX_TX_CLK_MASK) tx_clk_mask_q <= wdat & WM_TX_CLK_MASK;
            if (idx == IDX_RAIL_MODE) rail_mode_q <= wdat & WM_RAIL_MODE;
            if (idx == IDX_LINE_MODE_0) line_mode_0_q <= wdat & WM_LINE_MODE_0;
            if (idx == IDX_MASK_SIX) mask_six_q <= wdat & wm_mask_six;
            if (idx == IDX_IRQ_ENABLE) irq_enable_q <= wdat & WM_IRQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recovered clock routing

    logic [SEL_W-1:0] sel_vec [3];
    logic [2:0] rclk;

    assign sel_vec[0] = route_6_7_q[R6_LSB +: SEL_W]; // [RULE2]
    assign sel_vec[1] = route_6_7_q[R7_LSB +: SEL_W]; // [RULE1]
    assign sel_vec[2] = route_8_q[R8_LSB +: SEL_W]; // [RULE3]

    // one registered selector per output
    for (genvar g = 0; g < 3; g++) begin : g_rclk
        pcl_clk_sel u_sel (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .ch_clk_i(ch_clk_i),
            .sel_i(sel_vec[g]),
            .clk_o(rclk[g])
        );
    end

    assign recovered_clock_out_6_o = rclk[0];
    assign recovered_clock_out_7_o = rclk[1];
    assign recovered_clock_out_8_o = rclk[2];

    // rail mode outputs straight from the register
    assign rx_dual_rail_sel_o = rail_mode_q[RX_RAIL_BIT]; // [RULE11]
    assign tx_dual_rail_sel_o = rail_mode_q[TX_RAIL_BIT]; // [RULE12]

    ////////////////////////////////////////////////////////////////////////
    // in-band loop code qualification

    typedef enum logic [1:0] {
        PCL_Q_IDLE = 2'b00,
        PCL_Q_COUNT = 2'b01,
        PCL_Q_DONE = 2'b10
    } pcl_q_t;

    pcl_q_t q_state_q;
    pcl_q_t q_state_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic ms_tick;
    logic [CNT_W-1:0] qual_cnt_q;
    logic [CNT_W-1:0] qual_cnt_d;
    logic [CNT_W-1:0] target;
    logic kind_q;
    logic time_mode;
    logic step;
    logic reached;
    logic detect;
    pcl_dt_t dt_sel;

    assign dt_sel = pcl_dt_t'(detect_time_q[DT_LSB +: 2]);
    assign time_mode = dt_sel[1];
    // pattern modes count strobes, time modes count milliseconds
    assign target = (dt_sel == PCL_DT_16) ? PAT_COUNT_A : // [RULE4]
                    (dt_sel == PCL_DT_32) ? PAT_COUNT_B : // [RULE4]
                    (dt_sel == PCL_DT_4S) ? MS_COUNT_A : // [RULE5]
                    MS_COUNT_B; // [RULE5]
    assign step = time_mode ? ms_tick : inband_strobe_i;
    assign reached = (qual_cnt_q + CNT_W'(1)) >= target;
    assign ms_tick = (tick_cnt_q == TICK_W'(MS_CYCLES - 1));

    // millisecond divider held at zero outside the count state; restarts with each qualification
    // so a time figure is never short by more than one tick
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= '0;
        end else if (ms_tick || q_state_q != PCL_Q_COUNT) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
        end
    end

    // a gap in validity or a change of code kind restarts the count
    always_comb begin
        q_state_d = q_state_q;
        qual_cnt_d = qual_cnt_q;
        detect = 1'b0;
        case (q_state_q)
            PCL_Q_IDLE: begin
                qual_cnt_d = '0;
                if (inband_valid_i) q_state_d = PCL_Q_COUNT;
            end
            PCL_Q_COUNT: begin
                if (!inband_valid_i || inband_up_i != kind_q) begin
                    q_state_d = PCL_Q_IDLE;
                end else if (step && reached) begin
                    detect = 1'b1; // [RULE4] [RULE5]
                    q_state_d = PCL_Q_DONE;
                end else if (step) begin
                    qual_cnt_d = qual_cnt_q + CNT_W'(1);
                end
            end
            PCL_Q_DONE: begin
                // one detection per run of valid code
                if (!inband_valid_i || inband_up_i != kind_q) begin
                    q_state_d = PCL_Q_IDLE;
                end
            end
            default: q_state_d = PCL_Q_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_state_q <= PCL_Q_IDLE;
            qual_cnt_q <= '0;
            kind_q <= 1'b0;
        end else begin
            q_state_q <= q_state_d;
            qual_cnt_q <= qual_cnt_d;
            if (q_state_q == PCL_Q_IDLE) kind_q <= inband_up_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // automatic remote loop

    logic auto_ok;

    // software keeps the system side enable off while this one is set
    // [RULE8]
    assign auto_ok = auto_loop_q[AUTO_BIT] & // [RULE6]
                     ~line_mode_0_q[LOCAL_LOOP_BIT]; // [RULE7]

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            remote_loop_o <= 1'b0;
        end else if (!auto_ok) begin
            remote_loop_o <= 1'b0; // [RULE6] [RULE7]
        end else if (detect) begin
            remote_loop_o <= kind_q; // up closes, down releases [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins

    always_comb begin
        ev_set = 8'h00;
        ev_set[EV_UP] = detect & kind_q;
        ev_set[EV_DOWN] = detect & ~kind_q;
        ev_set[EV_TXA] = tx_clock_source_event_a_i;
        ev_set[EV_TXB] = tx_clock_source_event_b_i;
    end

    assign irq_clear = (wr && idx == IDX_IRQ_CLEAR) ? (wdat & WM_IRQ) : 8'h00;
    assign irq_status_d = (irq_status_q & ~irq_clear) | ev_set;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status_q <= RST_ZERO;
            irq_o <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            // mask bit 1 blocks; loop events via mask six [RULE9] [RULE10]
            irq_o <= |(irq_status_q & irq_enable_q & ~tx_clk_mask_q &
                       ~mask_six_q);
        end
    end
endmodule // pcl_regs

// file: testbench.sv
// self-checking bench for pcl_regs with the framer model beside it
// assumes a one cycle register answer and a shortened millisecond tick
`timescale 1ns/1ps
module testbench;
    import pcl_pkg::*;
    localparam int MS = 4;
    localparam logic [7:0] IX [9] = '{IDX_ROUTE_6_7, IDX_ROUTE_8,
        IDX_DETECT_TIME, IDX_AUTO_LOOP, IDX_TX_CLK_MASK, IDX_RAIL_MODE,
        IDX_LINE_MODE_0, IDX_MASK_SIX, IDX_IRQ_ENABLE};
    localparam logic [7:0] WM [9] = '{WM_ROUTE_6_7, WM_ROUTE_8,
        WM_DETECT_TIME, WM_AUTO_LOOP, WM_TX_CLK_MASK, WM_RAIL_MODE,
        WM_LINE_MODE_0, 8'h03, WM_IRQ};
    localparam logic [7:0] RV [9] = '{RST_ROUTE_6_7, RST_ROUTE_8,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, up = 1'b0;
    logic ev_a = 1'b0, ev_b = 1'b0, ack, valid, kind, strobe;
    logic o6, o7, o8, rx, tx, rl, irq;
    logic [3:0] sel = 4'h0;
    logic [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000, rdat;
    logic [7:0] ch, p;
    logic [15:0] rdq;
    int mismatches = 0, samples_checked = 0, n, cy;

    always #5 clk_i = ~clk_i;
    pcl_regs #(.MS_CYCLES(MS)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ch_clk_i(ch), .inband_valid_i(valid), .inband_up_i(kind),
        .inband_strobe_i(strobe), .tx_clock_source_event_a_i(ev_a),
        .tx_clock_source_event_b_i(ev_b), .recovered_clock_out_6_o(o6),
        .recovered_clock_out_7_o(o7), .recovered_clock_out_8_o(o8),
        .rx_dual_rail_sel_o(rx), .tx_dual_rail_sel_o(tx),
        .remote_loop_o(rl), .irq_o(irq));
    pcl_framer_model u_fr (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go),
        .up_i(up), .ch_clk_o(ch), .valid_o(valid), .up_o(kind),
        .strobe_o(strobe));
    ////////////////////////////////////////////////////////////
    // compares, one per kind of result
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chb(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {22'h00_0000, i, 2'h0};
        dat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdq = {8'h00, rdat[7:0]};
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] e);
        wb(1'b0, i, 8'h00);
        chk(nm, {8'h00, e}, rdq);
    endtask
    // one pattern run; n counts strobes, cy edges, until rl reaches lv
    task automatic run(input logic u, input logic [7:0] dt, input logic lv,
        input int lim);
        wb(1'b1, IDX_DETECT_TIME, dt);
        n = 0;
        cy = 0;
        up <= u;
        go <= 1'b1;
        while (cy < lim) begin
            @(posedge clk_i);
            cy++;
            if (rl === lv) break;
            n += int'(strobe);
        end
        go <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic ev(input logic b);
        ev_a <= !b;
        ev_b <= b;
        @(posedge clk_i);
        ev_a <= 1'b0;
        ev_b <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] ro [3] = '{IDX_IRQ_STATUS, IDX_IRQ_CLEAR, 8'h10};
        for (int k = 0; k < 9; k++) begin
            rc("reset value", IX[k], RV[k]);
            wb(1'b1, IX[k], 8'hff);
            rc("writable bits", IX[k], WM[k]);
            wb(1'b1, IX[k], 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, ro[k], 8'hff);
            rc("read only or unmapped", ro[k], 8'h00);
        end
    endtask
    task automatic t_route;
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, IDX_ROUTE_6_7, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
            wb(1'b1, IDX_ROUTE_8, {5'h00, c[2:0]});
            for (int k = 0; k < 8; k++) begin
                p = ch;
                @(posedge clk_i);
                chb("out7", p[c], o7);
                chb("out6", p[7 - c], o6);
                chb("out8", p[c], o8);
            end
        end
    endtask
    task automatic t_rail;
        for (int r = 0; r < 4; r++) begin
            wb(1'b1, IDX_RAIL_MODE, {6'h00, r[1:0]});
            repeat (2) @(posedge clk_i);
            chb("rx rail", r[1], rx);
            chb("tx rail", r[0], tx);
        end
    endtask
    task automatic t_txirq;
        wb(1'b1, IDX_IRQ_ENABLE, WM_IRQ);
        ev(1'b0);
        chb("irq event a", 1'b1, irq);
        rc("status a", IDX_IRQ_STATUS, 8'h08);
        wb(1'b1, IDX_TX_CLK_MASK, 8'h08);
        repeat (2) @(posedge clk_i);
        chb("irq a masked", 1'b0, irq);
        wb(1'b1, IDX_TX_CLK_MASK, 8'h18);
        ev(1'b1);
        chb("irq b masked", 1'b0, irq);
        rc("status ab", IDX_IRQ_STATUS, 8'h18);
        wb(1'b1, IDX_TX_CLK_MASK, 8'h08);
        repeat (2) @(posedge clk_i);
        chb("irq b open", 1'b1, irq);
        wb(1'b1, IDX_IRQ_CLEAR, 8'h18);
        repeat (2) @(posedge clk_i);
        chb("irq cleared", 1'b0, irq);
    endtask
    // system side switching is never enabled alongside this one
    task automatic t_loop;
        wb(1'b1, IDX_AUTO_LOOP, 8'h01);
        run(1'b1, 8'h00, 1'b1, 100);
        chk("16 patterns", 16'h0010, 16'(n));
        chb("loop irq", 1'b1, irq);
        wb(1'b1, IDX_MASK_SIX, 8'h01);
        repeat (2) @(posedge clk_i);
        chb("loop irq masked", 1'b0, irq);
        rc("up status", IDX_IRQ_STATUS, 8'h01);
        wb(1'b1, IDX_IRQ_CLEAR, 8'h1b);
        run(1'b0, 8'h10, 1'b0, 200);
        chk("32 patterns", 16'h0020, 16'(n));
        run(1'b1, 8'h20, 1'b1, 30000);
        chb("4 s", 1'b1, cy >= 16000 && cy <= 16010);
        run(1'b0, 8'h30, 1'b0, 30000);
        chb("5 s", 1'b1, cy >= 20000 && cy <= 20010);
        wb(1'b1, IDX_LINE_MODE_0, 8'h02);
        run(1'b1, 8'h00, 1'b1, 100);
        chb("local loop holds off", 1'b0, rl);
        wb(1'b1, IDX_LINE_MODE_0, 8'h00);
        wb(1'b1, IDX_AUTO_LOOP, 8'h00);
        run(1'b1, 8'h00, 1'b1, 100);
        chb("switching off", 1'b0, rl);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_route();
        t_rail();
        t_txirq();
        t_loop();
        close_out();
    end
    // whole run is near 40k cycles; cut a hang at 100k
    initial begin
        #1_000_000;
        mismatches++;
        close_out();
    end
endmodule // testbench
